// [hw/mtc_timer.v]
// modulo timer control: registers, source select, counter, overflow flag
// assumes a one-cycle register port and pins external to the clk domain
//
// Notes on behaviour
// - counter wrap from the limit to zero sets the overflow flag, bit 7.
// - flag clears by a read while set, then a write of 0 to it.
// - clear bit write of 1 or any limit write also clears the flag.
// - bit 6 enables the interrupt on the flag; reset clears it.
// - writing 1 to bit 5 zeroes the counter and flag; reads as 0.
// - writing 0 to the clear bit has no effect.
// - halt bit 4 holds the count; clearing resumes from the held value.
// - reset sets the halt bit.
// - unused bits of both control registers read zero.
// - source select bits 5:4 pick bus, fixed, pin falling, pin rising.
// - changing the source does not clear the counter.
// - reset selects the bus clock source.
// - divider select bits 3:0 divide by two to the power n.
// - divider encodings above eight divide by 256.
// - changing the divider does not clear the counter.
// - reset selects divide by one.
// - running counter increments per tick, wraps to zero after the limit.
// - limit zero makes the counter wrap at its full range.
// - pin clock is synchronised; it must stay below a quarter bus rate.
`timescale 1ns/1ns
module mtc_timer (
   input wire clk,
   input wire resetn,
   input wire [1:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   input wire fixed_freq_clock,
   input wire external_timer_clock,
   output reg irq,
   output reg [7:0] timer_count
);
`include "mtc_consts.vh"
   reg overflow_flag;
   reg overflow_irq_enable;
   reg counter_halt;
   reg [1:0] source_select;
   reg [3:0] divider_select;
   reg [7:0] timer_limit;
   reg clear_armed;
   reg ext_s1;
   reg ext_s2;
   reg ext_d;
   reg fix_s1;
   reg fix_s2;
   reg fix_d;
   reg src_tick;
   wire pre_tick;
   wire wrap;
   wire wr_ctrl;
   wire wr_limit;
   wire count_clear;
   reg [7:0] next_rdata;

   assign wr_ctrl = wr && (addr == `MTC_OFS_CTRL_STAT);
   assign wr_limit = wr && (addr == `MTC_OFS_LIMIT);
   assign count_clear = wr_limit || (wr_ctrl && wdata[`MTC_BIT_CLEAR]);

   // two-stage synchronisers for the pin and fixed clocks
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ext_s1 <= 1'b0;
         ext_s2 <= 1'b0;
         ext_d <= 1'b0;
         fix_s1 <= 1'b0;
         fix_s2 <= 1'b0;
         fix_d <= 1'b0;
      end else begin
         ext_s1 <= external_timer_clock;
         ext_s2 <= ext_s1;
         ext_d <= ext_s2;
         fix_s1 <= fixed_freq_clock;
         fix_s2 <= fix_s1;
         fix_d <= fix_s2;
      end
   end

   // source selection, evaluated live so a change takes effect at once
   always @* begin
      case (source_select)
         `MTC_SRC_BUS: src_tick = 1'b1;
         `MTC_SRC_FIXED: src_tick = fix_s2 && !fix_d;
         `MTC_SRC_EXT_FALL: src_tick = !ext_s2 && ext_d;
         `MTC_SRC_EXT_RISE: src_tick = ext_s2 && !ext_d;
         default: src_tick = 1'b1;
      endcase
   end

   // prescaler gated by halt so it freezes with the counter
   mtc_prescaler u_pre (
      .clk(clk),
      .resetn(resetn),
      .src_tick(src_tick && !counter_halt),
      .divider_select(divider_select),
      .tick(pre_tick)
   );

   // wrap at the limit, or at ff when the limit is zero
   assign wrap = (timer_limit == 8'h00) ? (timer_count == 8'hff) :
                 (timer_count == timer_limit);

   // counter, frozen while halted
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         timer_count <= 8'h00;
      end else if (count_clear) begin
         timer_count <= 8'h00;
      end else if (pre_tick && !counter_halt) begin
         timer_count <= wrap ? 8'h00 : timer_count + 8'h01;
      end
   end

   // control registers
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         overflow_irq_enable <= 1'b0;
         counter_halt <= `MTC_RST_HALT;
         source_select <= `MTC_RST_SRC;
         divider_select <= `MTC_RST_DIV;
         timer_limit <= `MTC_RST_LIMIT;
      end else begin
         if (wr_ctrl) begin
            overflow_irq_enable <= wdata[`MTC_BIT_IRQ_EN];
            counter_halt <= wdata[`MTC_BIT_HALT];
         end
         if (wr && addr == `MTC_OFS_SOURCE_CFG) begin
            source_select <= wdata[`MTC_SRC_HI:`MTC_SRC_LO];
            divider_select <= wdata[`MTC_DIV_HI:`MTC_DIV_LO];
         end
         if (wr_limit) begin
            timer_limit <= wdata;
         end
      end
   end

   // overflow flag with two-step clear; a new wrap wins over the write of 0 and disarms the clear
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         overflow_flag <= 1'b0;
         clear_armed <= 1'b0;
      end else if (pre_tick && !counter_halt && wrap && !count_clear) begin
         overflow_flag <= 1'b1;
         clear_armed <= 1'b0;
      end else if (count_clear) begin
         overflow_flag <= 1'b0;
         clear_armed <= 1'b0;
      end else if (wr_ctrl && !wdata[`MTC_BIT_OVF] && clear_armed) begin
         overflow_flag <= 1'b0;
         clear_armed <= 1'b0;
      end else if (rd && addr == `MTC_OFS_CTRL_STAT && overflow_flag) begin
         clear_armed <= 1'b1;
      end
   end

   // interrupt level
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= overflow_flag && overflow_irq_enable;
      end
   end

   // read mux
   always @* begin
      case (addr)
         `MTC_OFS_CTRL_STAT: next_rdata = {overflow_flag, overflow_irq_enable, 1'b0,
                                           counter_halt, 4'h0};
         `MTC_OFS_SOURCE_CFG: next_rdata = {2'h0, source_select, divider_select};
         `MTC_OFS_COUNT: next_rdata = timer_count;
         `MTC_OFS_LIMIT: next_rdata = timer_limit;
         default: next_rdata = 8'h00;
      endcase
   end

   // read data stands one cycle after the strobe, zero otherwise
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rdata <= 8'h00;
      end else begin
         rdata <= rd ? next_rdata : 8'h00;
      end
   end
endmodule

// [hw/mtc_consts.vh]
// constants of the modulo timer control block: offsets, fields, resets
// assumes inclusion by bare name from the design files
`ifndef MTC_CONSTS_VH
`define MTC_CONSTS_VH
`define MTC_ADDR_W 2
`define MTC_OFS_CTRL_STAT 2'h0
`define MTC_OFS_SOURCE_CFG 2'h1
`define MTC_OFS_COUNT 2'h2
`define MTC_OFS_LIMIT 2'h3
`define MTC_BIT_OVF 7
`define MTC_BIT_IRQ_EN 6
`define MTC_BIT_CLEAR 5
`define MTC_BIT_HALT 4
`define MTC_SRC_HI 5
`define MTC_SRC_LO 4
`define MTC_DIV_HI 3
`define MTC_DIV_LO 0
`define MTC_SRC_BUS 2'h0
`define MTC_SRC_FIXED 2'h1
`define MTC_SRC_EXT_FALL 2'h2
`define MTC_SRC_EXT_RISE 2'h3
`define MTC_DIV_MAX 4'h8
`define MTC_RST_SRC 2'h0
`define MTC_RST_DIV 4'h0
`define MTC_RST_HALT 1'b1
`define MTC_RST_LIMIT 8'h00
`endif

// [hw/mtc_prescaler.v]
// prescaler: 8-bit divider producing one-cycle ticks at source/2^n
// assumes src_tick is a one-cycle enable on clk
`timescale 1ns/1ns
module mtc_prescaler (
   input wire clk,
   input wire resetn,
   input wire src_tick,
   input wire [3:0] divider_select,
   output reg tick
);
`include "mtc_consts.vh"
   reg [7:0] div_count;
   reg [8:0] mask;
   // mask of low bits that must be all ones before a tick passes
   always @* begin
      if (divider_select >= `MTC_DIV_MAX) begin
         mask = 9'h0ff;
      end else begin
         mask = (9'h001 << divider_select) - 9'h001;
      end
   end
   // divider keeps running across selection changes, count not cleared
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         div_count <= 8'h00;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (src_tick) begin
            div_count <= div_count + 8'h01;
            tick <= ((div_count & mask[7:0]) == mask[7:0]);
         end
      end
   end
endmodule

// [test/mtc_timer_props.sv]
// checker for the modulo timer control ports
// assumes a bind onto mtc_timer from the bench top file
`timescale 1ns/1ns
module mtc_timer_props (
   input wire clk,
   input wire resetn,
   input wire [1:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   input wire [7:0] rdata,
   input wire irq,
   input wire [7:0] timer_count
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   // unused bits read back as zero
   property p_ctl_rsv; rd && addr == 2'h0 |=> (rdata & 8'h2f) == 8'h00; endproperty
   a_ctl_rsv: assert property (p_ctl_rsv) else $error("ctrl unused bits");
   property p_cfg_rsv; rd && addr == 2'h1 |=> rdata[7:6] == 2'h0; endproperty
   a_cfg_rsv: assert property (p_cfg_rsv) else $error("cfg unused bits");
   // counter clears, steps and holds
   property p_clr; wr && addr == 2'h0 && wdata[5] |=> timer_count == 8'h00; endproperty
   a_clr: assert property (p_clr) else $error("clear bit");
   property p_lim; wr && addr == 2'h3 |=> timer_count == 8'h00; endproperty
   a_lim: assert property (p_lim) else $error("limit write");
   property p_step;
      timer_count != $past(timer_count) |-> timer_count == $past(timer_count) + 8'h01
         || timer_count == 8'h00;
   endproperty
   a_step: assert property (p_step) else $error("count step");
   property p_halt;
      wr && addr == 2'h0 && wdata[5:4] == 2'h1 |=> ##1 $stable(timer_count)[*3];
   endproperty
   a_halt: assert property (p_halt) else $error("halted count moved");
   // interrupt level follows flag, one cycle late
   property p_irq_up;
      $rose(irq) |-> $past(timer_count) == 8'h00 && $past(timer_count, 2) != 8'h00;
   endproperty
   a_irq_up: assert property (p_irq_up) else $error("irq rose");
   property p_irq_dn; $fell(irq) |-> $past(wr, 2); endproperty
   a_irq_dn: assert property (p_irq_dn) else $error("irq fell");
endmodule

// [test/modulo_timer_control_test.sv]
// bench for the modulo timer control block: registers, flag, rates
// assumes mtc_timer and its checker are compiled first
`timescale 1ns/1ns
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin bad_count++; \
$display("BAD %0t %h %h", $time, a, b); end end
module modulo_timer_control_test;
   reg clk = 1'b0;
   reg resetn = 1'b0;
   reg [1:0] addr = 2'h0;
   reg [7:0] wdata = 8'h00;
   reg wr = 1'b0;
   reg rd = 1'b0;
   reg [7:0] cyc = 8'h00;
   reg [7:0] d;
   reg [7:0] c0;
   wire [7:0] rdata;
   wire irq;
   wire [7:0] timer_count;
   integer bad_count = 0;
   integer samples_checked = 0;
   integer i;
   mtc_timer dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .fixed_freq_clock(cyc[2]), .external_timer_clock(cyc[2]), .irq(irq),
      .timer_count(timer_count));
   initial begin
      forever #10 clk = ~clk;
   end
   // slow source and pin clocks, period eight cycles
   always @(posedge clk) cyc <= cyc + 8'h01;
   task wr_reg(input [1:0] a, input [7:0] v);
      begin
         @(posedge clk);
         wr <= 1'b1;
         addr <= a;
         wdata <= v;
         @(posedge clk);
         wr <= 1'b0;
      end
   endtask
   task rd_reg(input [1:0] a, output [7:0] v);
      begin
         @(posedge clk);
         rd <= 1'b1;
         addr <= a;
         @(posedge clk);
         rd <= 1'b0;
         #1 v = rdata;
      end
   endtask
   task chk_rd(input [1:0] a, input [7:0] e);
      begin
         rd_reg(a, d);
         `CHK(d, e)
      end
   endtask
   task t_reset;
      begin
         chk_rd(2'h0, 8'h10);
         chk_rd(2'h1, 8'h00);
         repeat (8) @(posedge clk);
         chk_rd(2'h2, 8'h00);
      end
   endtask
   task t_flag;
      begin
         wr_reg(2'h3, 8'h03);
         wr_reg(2'h0, 8'h40);
         repeat (40) if (irq !== 1'b1) @(negedge clk);
         `CHK(irq, 1'b1)
         wr_reg(2'h0, 8'h50);
         chk_rd(2'h0, 8'hd0);
         wr_reg(2'h0, 8'h50);
         repeat (2) @(posedge clk);
         #1 `CHK(irq, 1'b0)
         chk_rd(2'h0, 8'h50);
         rd_reg(2'h2, c0);
         `CHK(c0 <= 8'h03, 1'b1)
         wr_reg(2'h0, 8'h10);
         chk_rd(2'h2, c0);
         wr_reg(2'h0, 8'h70);
         chk_rd(2'h2, 8'h00);
         chk_rd(2'h0, 8'h50);
         wr_reg(2'h0, 8'h00);
         repeat (10) @(posedge clk);
         wr_reg(2'h3, 8'h00);
         chk_rd(2'h0, 8'h00);
      end
   endtask
   // window of five divided periods gives five counts
   task t_rate(input [7:0] cfg, input integer w);
      begin
         wr_reg(2'h1, cfg);
         chk_rd(2'h1, cfg & 8'h3f);
         repeat (w) @(posedge clk);
         rd_reg(2'h2, c0);
         repeat (w - 2) @(posedge clk);
         rd_reg(2'h2, d);
         `CHK(d - c0, 8'h05)
      end
   endtask
   task stop_test;
      begin
         $display("checks %0d bad %0d", samples_checked, bad_count);
         if (bad_count == 0 && samples_checked > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      resetn <= 1'b1;
      t_reset;
      t_flag;
      for (i = 0; i < 10; i++) t_rate(i[7:0], 5 << (i > 8 ? 8 : i));
      t_rate(8'h0f, 1280);
      t_rate(8'h10, 40);
      t_rate(8'h20, 40);
      t_rate(8'hf0, 40);
      stop_test;
   end
   // hang guard
   initial begin
      #400000;
      bad_count++;
      stop_test;
   end
endmodule
bind mtc_timer mtc_timer_props chk (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .irq,
   .timer_count);
